// *** rtl/ahb_host_port.v ***
// host controller driving the async parallel bus port of the device
// Functional notes
// [R1] host supplies device clock from own clock
// [R2] 18-bit address, 16-bit bidirectional data
// [R3] window select picks registers or buffer
// [R4] chip select held through whole access
// [R5] high byte enable with a0 steers bytes
// [R6] write strobe low only when writing
// [R7] read strobe low only when reading
// [R8] device holds wait until data ready
// [R9] device arbitrates, wait covers contention
// [R10] bus start and direction tied high
// [R11] device latches straps at reset release
// [R12] strap pattern 0100 picks this bus
// [R13] reserved strap held at one
// [R14] wait polarity strap sets wait level
// [R15] clock divide strap halves bus clock
// [R16] device bus clock at most 50MHz
// [R17] variable latency sixteen-bit cycles used
// [R18] minimum strobe time scales with clock
// [R19] zero precharge between accesses
// [R20] windows alias, host decodes upper bits
// [R21] strobe two cycles after chip select
// [R22] three consecutive ready samples before proceeding
// [R23] selects held one cycle after strobe
// [R24] host drives data only when writing
// [R25] device synchronises strobes internally
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ahb_port_map.vh"
module ahb_host_port
#(
	parameter          AW = 18,
	parameter          DW = 16,
	parameter [2:0]    MIN_STROBE = `AHB_MIN_STROBE,
	parameter [15:0]   TIMEOUT = `AHB_TIMEOUT_CYC
)
(
	input  wire            i_clk_sys,
	input  wire            i_rst_n,
	input  wire [7:0]      i_reg_addr,
	input  wire [31:0]     i_reg_wdata,
	input  wire            i_reg_wr,
	input  wire            i_reg_rd,
	output reg  [31:0]     o_reg_rdata,
	output wire            o_host_clock_output,
	output reg             o_device_reset_n,
	output reg  [6:0]      o_strap,
	output reg  [AW-1:0]   o_address_inputs,
	output reg             o_host_window_address_bit,
	output reg             o_host_chip_select_n,
	output reg             o_high_byte_enable_n,
	output reg             o_write_strobe_n,
	output reg             o_host_read_strobe_n,
	output wire            o_bus_start_in,
	output wire            o_rd_wr_dir,
	output reg  [DW-1:0]   o_data_lines,
	output reg             o_data_lines_oe,
	input  wire [DW-1:0]   i_data_lines,
	input  wire            i_wait_pin
);
	localparam [2:0] ST_IDLE  = 3'd0;
	localparam [2:0] ST_SETUP = 3'd1;
	localparam [2:0] ST_STRB  = 3'd2;
	localparam [2:0] ST_WAIT  = 3'd3;
	localparam [2:0] ST_HOLD  = 3'd4;

	reg  [2:0]     state_q;
	reg  [2:0]     cnt_q;
	reg  [1:0]     rdy_cnt_q;
	reg  [15:0]    to_q;
	reg            is_read_q;
	reg  [1:0]     be_q;
	reg            mem_q;
	reg  [AW-1:0]  addr_q;
	reg  [DW-1:0]  wdata_q;
	reg  [DW-1:0]  rdata_q;
	reg            done_q;
	reg            tmo_q;
	reg  [2:0]     min_strb_q;
	reg            rst_pend_q;
	wire           ready;
	wire           busy;
	wire           go;
	wire           strb_on;
	wire           hold_done;
	wire [DW-1:0]  din_s1;
	reg  [DW-1:0]  din_s1_q;
	reg  [DW-1:0]  din_s2_q;

	// last cycle of the hold phase, where select and data drive end
	function hold_last;
		input [2:0]  st;
		input [2:0]  cn;
	begin
		hold_last = (st == ST_HOLD) && (cn + 3'd1 >= `AHB_HOLD_CYC);
	end
	endfunction

	// strobe window: last setup cycle, strobe phase, then the wait phase
	// up to the final ready sample; a timeout also lifts the strobe
	function strobe_phase;
		input [2:0]  st;
		input [2:0]  cn;
		input        rdy;
		input [1:0]  rc;
		input [15:0] tc;
	begin
		strobe_phase = (st == ST_SETUP && cn + 3'd1 >= `AHB_SETUP_CYC)
			|| (st == ST_STRB)
			|| (st == ST_WAIT && tc < TIMEOUT
			&& !(rdy && rc + 2'd1 >= `AHB_READY_SAMPLES));
	end
	endfunction

	// both strobes and the select share these decodes
	assign strb_on = strobe_phase(state_q, cnt_q, ready, rdy_cnt_q, to_q);
	assign hold_done = hold_last(state_q, cnt_q);

	assign busy = (state_q != ST_IDLE);
	// a start is taken only while idle and the device is out of reset
	assign go = i_reg_wr && (i_reg_addr == `AHB_REG_CTRL)
		&& i_reg_wdata[`AHB_CTRL_GO] && !busy && o_device_reset_n;
	// device clock is our own clock, forwarded; at 20 MHz it stays under
	// the device bus limit with no divide needed [R1] [R16]
	assign o_host_clock_output = i_clk_sys;
	// unused inputs of this bus mode are tied high [R10]
	assign o_bus_start_in = 1'b1;
	assign o_rd_wr_dir = 1'b1;
	assign din_s1 = i_data_lines;

	// qualified ready from the wait pin at the strapped polarity [R14]
	// ready lags the pin by three flops; the device raises wait at once
	ahb_ready_sync u_rdy
	(
		.i_clk_sys          (i_clk_sys),
		.i_rst_n            (i_rst_n),
		.i_wait_pin         (i_wait_pin),
		.i_wait_active_high (o_strap[`AHB_STRAP_WPOL]),
		.o_ready            (ready)
	);

	// data lines come from off-chip, so two flops before use
	// read data are taken two flops late; the device holds them while ready
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			din_s1_q <= {DW{1'b0}};
			din_s2_q <= {DW{1'b0}};
		end
		else
		begin
			din_s1_q <= din_s1;
			din_s2_q <= din_s1_q;
		end
	end

	// strap and device reset control; straps only change with reset low
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_strap <= `AHB_STRAP_RST;                   // [R12]
			o_device_reset_n <= 1'b0;
			rst_pend_q <= 1'b1;
			min_strb_q <= MIN_STROBE;
		end
		else
		begin
			rst_pend_q <= 1'b0;
			if (rst_pend_q)
				o_device_reset_n <= 1'b1;  // straps settled a cycle before [R11]
			if (i_reg_wr && (i_reg_addr == `AHB_REG_STRAP) && !busy)
			begin
				// reserved strap forced to one, bus bits kept fixed
				o_strap <= {i_reg_wdata[`AHB_STRAP_CDIV],
					i_reg_wdata[`AHB_STRAP_WPOL], 1'b0,
					1'b1, 3'b100};                          // [R13] [R12] [R15]
				o_device_reset_n <= 1'b0;
				rst_pend_q <= 1'b1;
			end
			// a zero setting would leave no strobe at all, so it reads as one
			if (i_reg_wr && (i_reg_addr == `AHB_REG_TIMING))
				min_strb_q <= (i_reg_wdata[2:0] == 3'd0) ? 3'd1
					: i_reg_wdata[2:0];                     // [R18]
		end
	end

	// access sequencer for the variable latency cycle [R17]
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_q <= ST_IDLE;
			cnt_q <= 3'd0;
			rdy_cnt_q <= 2'd0;
			to_q <= 16'h0000;
			is_read_q <= 1'b0;
			be_q <= 2'b00;
			mem_q <= 1'b0;
			addr_q <= {AW{1'b0}};
			wdata_q <= {DW{1'b0}};
			rdata_q <= {DW{1'b0}};
			done_q <= 1'b0;
			tmo_q <= 1'b0;
		end
		else
		begin
			if (i_reg_wr && (i_reg_addr == `AHB_REG_ADDR) && !busy)
				addr_q <= i_reg_wdata[AW-1:0];
			if (i_reg_wr && (i_reg_addr == `AHB_REG_WDATA) && !busy)
				wdata_q <= i_reg_wdata[DW-1:0];
			if (go)
			begin
				is_read_q <= i_reg_wdata[`AHB_CTRL_READ];
				be_q <= i_reg_wdata[`AHB_CTRL_BE_HI:`AHB_CTRL_BE_LO];
				mem_q <= i_reg_wdata[`AHB_CTRL_MEM];            // [R3]
				done_q <= 1'b0;
				tmo_q <= 1'b0;
			end
			case (state_q)
				ST_IDLE:
				begin
					cnt_q <= 3'd0;
					// no precharge gap: a new access may start at once [R19]
					if (go)
						state_q <= ST_SETUP;
				end
				ST_SETUP:
				begin
					cnt_q <= cnt_q + 3'd1;
					if (cnt_q + 3'd1 >= `AHB_SETUP_CYC)        // [R21]
					begin
						state_q <= ST_STRB;
						cnt_q <= 3'd0;
					end
				end
				ST_STRB:
				begin
					cnt_q <= cnt_q + 3'd1;
					rdy_cnt_q <= 2'd0;
					to_q <= 16'h0000;
					if (cnt_q + 3'd1 >= min_strb_q)             // [R18]
						state_q <= ST_WAIT;
				end
				ST_WAIT:
				begin
					to_q <= to_q + 16'h0001;
					// consecutive ready samples only; a gap restarts [R22]
					if (!ready)
						rdy_cnt_q <= 2'd0;
					else if (rdy_cnt_q + 2'd1 >= `AHB_READY_SAMPLES)
					begin
						if (is_read_q)
							rdata_q <= din_s2_q;
						state_q <= ST_HOLD;
						cnt_q <= 3'd0;
					end
					else
						rdy_cnt_q <= rdy_cnt_q + 2'd1;
					// a hung device must not lock the controller forever
					if (to_q >= TIMEOUT)
					begin
						tmo_q <= 1'b1;
						state_q <= ST_HOLD;
						cnt_q <= 3'd0;
					end
				end
				ST_HOLD:
				begin
					cnt_q <= cnt_q + 3'd1;
					// done rises as select lifts, so a poll sees a whole access
					if (hold_done)                             // [R23]
					begin
						state_q <= ST_IDLE;
						done_q <= 1'b1;
					end
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// pin drivers, registered so pins never glitch
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_host_chip_select_n <= 1'b1;
			o_high_byte_enable_n <= 1'b1;
			o_write_strobe_n <= 1'b1;
			o_host_read_strobe_n <= 1'b1;
			o_address_inputs <= {AW{1'b0}};
			o_host_window_address_bit <= 1'b0;
			o_data_lines <= {DW{1'b0}};
			o_data_lines_oe <= 1'b0;
		end
		else
		begin
			// chip select covers setup, strobe, wait and hold [R4]
			o_host_chip_select_n <= !(go || (busy && !hold_done));
			if (go)
			begin
				o_address_inputs <= {addr_q[AW-1:1],
					i_reg_wdata[`AHB_CTRL_BE_LO] ? 1'b0 : 1'b1};  // [R2] [R5]
				o_host_window_address_bit <= i_reg_wdata[`AHB_CTRL_MEM];
				o_high_byte_enable_n <= !i_reg_wdata[`AHB_CTRL_BE_HI]; // [R5]
				o_data_lines <= wdata_q;
			end
			// strobes run from strobe entry until enough ready samples
			// only the direction bit picks which strobe moves
			o_write_strobe_n <= !(!is_read_q && strb_on); // [R6]
			o_host_read_strobe_n <= !(is_read_q && strb_on); // [R7]
			// drive data only for writes, never while reading [R24]
			o_data_lines_oe <= (go && !i_reg_wdata[`AHB_CTRL_READ])
				|| (busy && !is_read_q && !hold_done);
		end
	end

	// register read port, data one cycle after the strobe
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_reg_rdata <= 32'h0000_0000;
		else if (i_reg_rd)
		begin
			case (i_reg_addr)
				`AHB_REG_CTRL:   o_reg_rdata <= {27'h0, mem_q, be_q, is_read_q,
					1'b0};
				`AHB_REG_ADDR:   o_reg_rdata <= {{(32-AW){1'b0}}, addr_q};
				`AHB_REG_WDATA:  o_reg_rdata <= {{(32-DW){1'b0}}, wdata_q};
				`AHB_REG_RDATA:  o_reg_rdata <= {{(32-DW){1'b0}}, rdata_q};
				`AHB_REG_STATUS: o_reg_rdata <= {29'h0, tmo_q, done_q, busy};
				`AHB_REG_STRAP:  o_reg_rdata <= {25'h0, o_strap};
				`AHB_REG_TIMING: o_reg_rdata <= {29'h0, min_strb_q};
				default:         o_reg_rdata <= 32'h0000_0000;
			endcase
		end
		else
			o_reg_rdata <= 32'h0000_0000;
	end
endmodule // ahb_host_port
`default_nettype wire

// *** rtl/ahb_port_map.vh ***
// constants for the host-side async bus port controller
`ifndef AHB_PORT_MAP_VH
`define AHB_PORT_MAP_VH
// own register offsets (byte addresses, one word each)
`define AHB_REG_CTRL      8'h00
`define AHB_REG_ADDR      8'h04
`define AHB_REG_WDATA     8'h08
`define AHB_REG_RDATA     8'h0C
`define AHB_REG_STATUS    8'h10
`define AHB_REG_STRAP     8'h14
`define AHB_REG_TIMING    8'h18
// ctrl fields (write)
`define AHB_CTRL_GO       0
`define AHB_CTRL_READ     1
`define AHB_CTRL_BE_LO    2
`define AHB_CTRL_BE_HI    3
`define AHB_CTRL_MEM      4
// status fields
`define AHB_ST_BUSY       0
`define AHB_ST_DONE       1
`define AHB_ST_TIMEOUT    2
// strap register fields and reset value: bus sel[2:0], rsvd, endian,
// wait polarity, clock divide -> pattern for the little-endian mode
`define AHB_STRAP_W       7
`define AHB_STRAP_RST     7'h0C
`define AHB_STRAP_BUS_LSB 0
`define AHB_STRAP_RSVD    3
`define AHB_STRAP_WPOL    5
`define AHB_STRAP_CDIV    6
// timing: setup cycles before strobe, ready samples, hold after strobe
`define AHB_SETUP_CYC     3'd2
`define AHB_READY_SAMPLES 2'd3
`define AHB_HOLD_CYC      3'd1
`define AHB_MIN_STROBE    3'd1
`define AHB_TIMEOUT_CYC   16'h0400
// device windows: registers and display buffer, 256K each
`define AHB_WIN_BITS      18
`define AHB_BUF_BYTES     32'h0002_8000
`endif

// *** rtl/ahb_ready_sync.v ***
// two-flop synchroniser and qualifier for the device wait pin
`timescale 1ns/1ps
`default_nettype none
module ahb_ready_sync
(
	input  wire       i_clk_sys,
	input  wire       i_rst_n,
	input  wire       i_wait_pin,
	input  wire       i_wait_active_high,
	output reg        o_ready
);
	reg               s1_q;
	reg               s2_q;

	// first stage feeds only the second stage
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			o_ready <= 1'b0;
		end
		else
		begin
			s1_q <= i_wait_pin;
			s2_q <= s1_q;
			// ready when wait is not at its asserted level
			o_ready <= (s2_q != i_wait_active_high);
		end
	end
endmodule // ahb_ready_sync
`default_nettype wire

// *** tb/ahb_dev_model.sv ***
// device model: latched straps, wait, byte lanes, small memory
`timescale 1ns/1ps
`default_nettype none
module ahb_dev_model
(
	input wire logic        i_clk,
	input wire logic        i_rst_n,
	input wire logic [6:0]  i_strap,
	input wire logic [17:0] i_ab,
	input wire logic        i_mr,
	input wire logic        i_cs_n,
	input wire logic        i_hi_n,
	input wire logic        i_we_n,
	input wire logic        i_rd_n,
	input wire logic [15:0] i_hd,
	input wire logic        i_hoe,
	input wire logic [7:0]  i_lat,
	output logic     [15:0] o_db,
	output logic            o_wait
);
	logic [15:0] mem [0:31];
	logic [15:0] last_q;
	logic [7:0]  cnt_q;
	logic        pol_q, div_q, tick_q;
	logic        sel_s1_q, sel_s2_q;
	// strobes count only under select; upper bits alias
	wire       sel  = !i_cs_n && !(i_we_n && i_rd_n);
	// wait rises with the strobe and holds until the synced strobe has
	// been counted through the arbitration latency
	wire       busy = sel && (!sel_s2_q || cnt_q != i_lat);
	wire [4:0] ix   = {i_mr, i_ab[4:1]}; // window picks block
	// options fixed as reset rises
	always @(posedge i_rst_n) {div_q, pol_q} <= i_strap[6:5];
	// arbitration holds the host for i_lat bus ticks
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt_q  <= 8'h00;
			tick_q <= 1'b0;
			last_q <= 16'h0000;
			sel_s1_q <= 1'b0;
			sel_s2_q <= 1'b0;
		end
		else
		begin
			tick_q <= !div_q || !tick_q;
			last_q <= o_db;
			sel_s1_q <= sel;
			sel_s2_q <= sel_s1_q;
			if (!sel)
				cnt_q <= 8'h00;
			else if (busy && tick_q && sel_s2_q)
				cnt_q <= cnt_q + 8'h01;
			// lanes take what is on the wire, so an undriven bus writes junk
			if (sel && !i_we_n && !busy && !i_ab[0])
				mem[ix][7:0] <= o_db[7:0];
			if (sel && !i_we_n && !busy && !i_hi_n)
				mem[ix][15:8] <= o_db[15:8];
		end
	end
	// wire level: host data, granted read data, else a moving pattern
	always_comb
	begin
		if (i_hoe)
			o_db = i_hd;
		else if (sel && !i_rd_n && !busy)
			o_db = mem[ix];
		else
			o_db = ~last_q;
	end
	// pull-up when deselected, strapped level while busy
	assign o_wait = i_cs_n ? 1'b1 : busy ? pol_q : !pol_q;
endmodule // ahb_dev_model
`default_nettype wire

// *** tb/ahb_host_port_monitor.sv ***
// assertion checker bound to the host port controller pins
`timescale 1ns/1ps
`default_nettype none
module ahb_host_port_monitor
(
	input wire logic       i_clk_sys,
	input wire logic       i_rst_n,
	input wire logic [6:0] o_strap,
	input wire logic       o_host_chip_select_n,
	input wire logic       o_write_strobe_n,
	input wire logic       o_host_read_strobe_n,
	input wire logic       o_bus_start_in,
	input wire logic       o_rd_wr_dir,
	input wire logic       o_data_lines_oe,
	input wire logic       i_wait_pin
);
	// high while neither strobe is active
	wire idle = o_write_strobe_n & o_host_read_strobe_n;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	property p_cs; !idle |-> !o_host_chip_select_n; endproperty
	a_cs: assert property (p_cs) else $error("strobe without cs");
	property p_dir; !o_write_strobe_n |-> o_host_read_strobe_n; endproperty
	a_dir: assert property (p_dir) else $error("both strobes");
	property p_tie; o_bus_start_in && o_rd_wr_dir; endproperty
	a_tie: assert property (p_tie) else $error("unused pins low");
	property p_bus; o_strap[4:0] == 5'h0C; endproperty
	a_bus: assert property (p_bus) else $error("bus straps");
	property p_set; $fell(idle) |-> !$past(o_host_chip_select_n, 2); endproperty
	a_set: assert property (p_set) else $error("strobe early");
	property p_hld; $rose(idle) |-> !o_host_chip_select_n; endproperty
	a_hld: assert property (p_hld) else $error("cs dropped");
	property p_oe; o_data_lines_oe |-> o_host_read_strobe_n; endproperty
	a_oe: assert property (p_oe) else $error("drive in read");
	// a wait seen now must still hold the strobe through sync and sampling
	property p_rdy; !idle && i_wait_pin == o_strap[5] |=> !idle [*3]; endproperty
	a_rdy: assert property (p_rdy) else $error("ended in wait");
	c_wr: cover property (!o_write_strobe_n);
	c_rd: cover property (!o_host_read_strobe_n);
	c_st: cover property ($changed(o_strap));
endmodule // ahb_host_port_monitor
bind ahb_host_port ahb_host_port_monitor u_mon
(
	.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .o_strap(o_strap),
	.o_host_chip_select_n(o_host_chip_select_n),
	.o_write_strobe_n(o_write_strobe_n),
	.o_host_read_strobe_n(o_host_read_strobe_n),
	.o_bus_start_in(o_bus_start_in), .o_rd_wr_dir(o_rd_wr_dir),
	.o_data_lines_oe(o_data_lines_oe), .i_wait_pin(i_wait_pin)
);
`default_nettype wire

// *** tb/async_host_bus_port_tb.sv ***
// self-checking bench: host port driving the device model
`timescale 1ns/1ps
`default_nettype none
`include "ahb_port_map.vh"
module async_host_bus_port_tb;
	logic        clk, hclk, rst_n, wr, rd, rd_d1, dn, mr, win;
	logic        cs_n, hi_n, we_n, re_n, dev_n, hoe, wt;
	logic [7:0]  adr, lat;
	logic [31:0] wd, rdata, x;
	logic [63:0] q[$];
	logic [63:0] e;
	logic [17:0] ab, a;
	logic [15:0] hd, db, d;
	logic [15:0] sh [0:31];
	logic [6:0]  strap;
	int          fails, checks, i, n;
	ahb_host_port DUT
	(
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_reg_addr(adr),
		.i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
		.o_host_clock_output(hclk), .o_device_reset_n(dev_n), .o_strap(strap),
		.o_address_inputs(ab), .o_host_window_address_bit(mr),
		.o_host_chip_select_n(cs_n), .o_high_byte_enable_n(hi_n),
		.o_write_strobe_n(we_n), .o_host_read_strobe_n(re_n),
		.o_bus_start_in(), .o_rd_wr_dir(), .o_data_lines(hd),
		.o_data_lines_oe(hoe), .i_data_lines(db), .i_wait_pin(wt)
	);
	ahb_dev_model u_dev
	(
		.i_clk(hclk), .i_rst_n(dev_n), .i_strap(strap), .i_ab(ab),
		.i_mr(mr), .i_cs_n(cs_n), .i_hi_n(hi_n), .i_we_n(we_n),
		.i_rd_n(re_n), .i_hd(hd), .i_hoe(hoe), .i_lat(lat),
		.o_db(db), .o_wait(wt)
	);
	function automatic logic [31:0] xs();
	begin
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	end
	endfunction
	task automatic bwr(input [7:0] ra, input [31:0] v);
	begin
		@(posedge clk);
		adr <= ra;
		wd  <= v;
		wr  <= 1'b1;
		@(posedge clk);
		wr  <= 1'b0;
	end
	endtask
	// read; bits under m must equal v, m of zero only polls
	task automatic brd(input [7:0] ra, input [31:0] m, input [31:0] v);
	begin
		@(posedge clk);
		q.push_back({m, v});
		adr <= ra;
		rd  <= 1'b1;
		@(posedge clk);
		rd  <= 1'b0;
	end
	endtask
	// one device access, poll for done, reads checked against shadow
	task automatic acc(input w, input [1:0] be, input [15:0] v);
	begin
		lat <= 8'(xs() % 8);
		bwr(`AHB_REG_ADDR, {14'h0000, a});
		bwr(`AHB_REG_WDATA, {16'h0000, v});
		bwr(`AHB_REG_CTRL, {27'h000_0000, win, be, !w, 1'b1});
		dn = 1'b0;
		for (n = 0; n < 200 && !dn; n++)
		begin
			brd(`AHB_REG_STATUS, '0, '0);
			#1 dn = rdata[1];
		end
		brd(`AHB_REG_STATUS, 32'h0000_0007, 32'h0000_0002);
		if (w && be[0]) sh[{win, a[4:1]}][7:0] = v[7:0];
		if (w && be[1]) sh[{win, a[4:1]}][15:8] = v[15:8];
		if (!w) brd(`AHB_REG_RDATA, 32'h0000_FFFF, {16'h0000, sh[{win, a[4:1]}]});
	end
	endtask
	task end_of_test;
	begin
		if (fails == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	// each read answer against the oldest note
	always @(posedge clk)
	begin
		if (rd_d1 && q.size() > 0)
		begin
			e = q.pop_front();
			if (e[63:32] != 0)
			begin
				checks++;
				if ((rdata & e[63:32]) !== e[31:0])
				begin
					fails++;
					$display("wrong value at %0t: %h not %h", $time, rdata, e[31:0]);
				end
			end
		end
		rd_d1 <= rd;
	end
	initial
	begin
		clk = 1'b0;
		forever #25 clk = !clk; // 20 MHz keeps the bus clock low
	end
	// hang guard, far beyond the expected run
	initial
	begin
		#2_000_000;
		fails++;
		end_of_test;
	end
	initial
	begin
		{rst_n, wr, rd, adr, wd, lat, win, a} = '0;
		x = 32'h0000_0017;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		brd(`AHB_REG_STRAP, 32'h0000_007F, 32'h0000_000C);
		brd(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
		bwr(`AHB_REG_TIMING, 32'h0000_0000);
		brd(`AHB_REG_TIMING, 32'h0000_0007, 32'h0000_0001);
		for (i = 0; i < 24; i++)
		begin
			if (i == 12)
			begin
				bwr(`AHB_REG_STRAP, 32'h0000_0060);
				bwr(`AHB_REG_TIMING, 32'h0000_0003);
			end
			a = 18'(xs()) & 18'h3_FFFE;
			win = i[0];
			d = 16'(xs());
			acc(1'b1, 2'b11, d);
			acc(1'b1, 2'b01, ~d);
			acc(1'b1, 2'b10, d ^ 16'hA5A5);
			acc(1'b0, 2'b11, d);
		end
		brd(`AHB_REG_STRAP, 32'h0000_007F, 32'h0000_006C);
		brd(`AHB_REG_TIMING, 32'h0000_0007, 32'h0000_0003);
		end_of_test;
	end
endmodule // async_host_bus_port_tb
`default_nettype wire
